/* File: hdl/cfgio_pkg.sv */
// shared constants for the configurable i/o port sequencer
package cfgio_pkg;
  localparam int NPIN         = 8;
  localparam int DATA_W       = 12;
  localparam int FRAME_W      = 16;
  localparam int CH_W         = 3;
  localparam int CNT_W        = 5;
  localparam int TMR_W        = 10;
  // timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CONV_TIME_NS  = 2000;
  localparam int CONV_CYC      = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  // command word layout
  localparam int B_IS_DAC  = 15;
  localparam int ADDR_HI   = 14;
  localparam int ADDR_LO   = 11;
  localparam int CH_HI     = 14;
  localparam int CH_LO     = 12;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  // control register addresses
  localparam logic [3:0] A_NOP      = 4'h0;
  localparam logic [3:0] A_DAC_RB   = 4'h1;
  localparam logic [3:0] A_ADC_SEQ  = 4'h2;
  localparam logic [3:0] A_GP_CTRL  = 4'h3;
  localparam logic [3:0] A_ADC_CFG  = 4'h4;
  localparam logic [3:0] A_DAC_CFG  = 4'h5;
  localparam logic [3:0] A_PULLDOWN = 4'h6;
  localparam logic [3:0] A_RB_LOAD  = 4'h7;
  localparam logic [3:0] A_GPO_CFG  = 4'h8;
  localparam logic [3:0] A_GPO_DATA = 4'h9;
  localparam logic [3:0] A_GPI_CFG  = 4'hA;
  localparam logic [3:0] A_PWR_DOWN = 4'hB;
  // field positions
  localparam int B_BUSY_EN   = 8;
  localparam int B_ADC_RANGE = 5;
  localparam int B_DAC_GAIN  = 4;
  localparam int B_GPIO_RD   = 10;
  localparam int B_REF_EN    = 9;
  localparam int B_RB_EN     = 6;
  localparam int RB_A_HI     = 5;
  localparam int RB_A_LO     = 2;
  localparam int DRB_EN_HI   = 4;
  localparam int DRB_EN_LO   = 3;
  localparam logic [1:0] DRB_ON = 2'h3;
  // load deferral modes
  localparam logic [1:0] LD_IMMED = 2'h0;
  localparam logic [1:0] LD_DEFER = 2'h1;
  localparam logic [1:0] LD_LOAD  = 2'h2;
  // reset values and flag pin
  localparam logic [7:0] PULLDOWN_RST = 8'hFF;
  localparam logic [2:0] LINK_RST     = 3'h2;
  localparam int FLAG_PIN = 7;
endpackage : cfgio_pkg

/* File: hdl/cfgio_seq.sv */
// configurable i/o port: serial command decode, dac, adc sequencer, gpio
//
// Notes on behaviour
// - each pin dac, adc, digital in or out
// - dac codes binary 0..4095, one shared gain
// - dac updates at once only while load mode is immediate
// - sequence write selects channels, first tracks
// - frame falls start conversions, ship previous result
// - result frame: zero, channel, twelve bits
// - conversion lasts 2 us, no overlap
// - flag pin low busy, high result ready
// - shared adc range bit D5, binary coding
// - dac plus adc pin: dac drives, converted
// - output-enabled pins driven from write data
// - gpio read bit sends input states next
// - in-and-out pin reports actual pin state
// - reference off at reset, D9 enables
// - D15 picks control write or dac write
// - shift on sclk falls, execute on sync rise
`timescale 1ns/1ps
module cfgio_seq
  import cfgio_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_sclk,
  input  wire logic                   i_sync_n,
  input  wire logic                   i_sdi,
  output logic                        o_sdo,
  input  wire logic [NPIN-1:0]        i_pin,
  output logic      [NPIN-1:0]        o_pin,
  output logic      [NPIN-1:0]        o_pin_oe,
  output logic      [NPIN*DATA_W-1:0] o_dac_code,
  output logic      [NPIN-1:0]        o_dac_en,
  output logic                        o_dac_gain,
  output logic      [NPIN-1:0]        o_adc_en,
  output logic                        o_adc_range,
  output logic      [CH_W-1:0]        o_adc_chan,
  output logic                        o_adc_track,
  output logic                        o_adc_busy,
  input  wire logic [DATA_W-1:0]      i_adc_result,
  output logic      [NPIN-1:0]        o_pulldown,
  output logic                        o_ref_en
);
  // next selected channel after cur, wrapping round
  function automatic logic [CH_W-1:0] next_chan(input logic [NPIN-1:0] mask,
                                                input logic [CH_W-1:0] cur);
    logic [CH_W-1:0] c;
    logic [CH_W-1:0] r;
    r = cur;
    c = cur;
    for (int k = 0; k < NPIN; k++) begin
      c = c + 3'h1;
      if (mask[c] && r == cur) begin
        r = c;
      end
    end
    return r;
  endfunction : next_chan

  ////////////////////////////////////////////////////////////////////////
  logic [2:0]          link_s;
  logic [NPIN-1:0]     pin_s;
  logic                sclk_prev_reg;
  logic                sync_prev_reg;
  logic                sclk_fall;
  logic                sync_fall;
  logic                sync_rise;
  logic [FRAME_W-1:0]  rx_reg;
  logic [FRAME_W-1:0]  tx_reg;
  logic [CNT_W-1:0]    cnt_reg;
  logic                exec;
  logic [3:0]          addr;
  logic [CH_W-1:0]     wch;
  logic [DATA_W-1:0]   in_reg  [NPIN];
  logic [DATA_W-1:0]   dac_reg [NPIN];
  logic [1:0]          ld_mode_reg;
  logic [NPIN-1:0]     seq_mask_reg;
  logic [NPIN-1:0]     adc_cfg_reg;
  logic [NPIN-1:0]     dac_cfg_reg;
  logic [NPIN-1:0]     gpo_cfg_reg;
  logic [NPIN-1:0]     gpo_data_reg;
  logic [NPIN-1:0]     gpi_cfg_reg;
  logic                busy_en_reg;
  logic                gpio_rd_reg;
  logic                rb_pend_reg;
  logic [3:0]          rb_addr_reg;
  logic                drb_pend_reg;
  logic [CH_W-1:0]     drb_ch_reg;
  logic [CH_W-1:0]     chan_reg;
  logic [CH_W-1:0]     conv_ch_reg;
  logic                busy_reg;
  logic [TMR_W-1:0]    tmr_reg;
  logic                res_valid_reg;
  logic [FRAME_W-1:0]  res_frame_reg;
  logic                conv_start;
  logic                conv_done;

  cfgio_sync2 #(.W(3), .RST_VAL(LINK_RST)) u_link_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_sclk, i_sync_n, i_sdi}),
    .o_q     (link_s)
  );
  cfgio_sync2 #(.W(NPIN), .RST_VAL('0)) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     (i_pin),
    .o_q     (pin_s)
  );

  // edges of the link, found on the synchronised copies
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_prev_reg <= 1'b0;
      sync_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= link_s[2];
      sync_prev_reg <= link_s[1];
    end
  end
  assign sclk_fall = sclk_prev_reg & ~link_s[2] & ~link_s[1];
  assign sync_fall = sync_prev_reg & ~link_s[1];
  assign sync_rise = ~sync_prev_reg & link_s[1];
  assign exec      = sync_rise && cnt_reg == FRAME_BITS;
  assign addr      = rx_reg[ADDR_HI:ADDR_LO];
  assign wch       = rx_reg[CH_HI:CH_LO];

  ////////////////////////////////////////////////////////////////////////
  // input shift; bits past the sixteenth are dropped
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_reg  <= '0;
      cnt_reg <= '0;
    end else if (sync_fall || sync_rise) begin
      cnt_reg <= '0;
    end else if (sclk_fall && cnt_reg != FRAME_BITS) begin
      rx_reg  <= {rx_reg[FRAME_W-2:0], link_s[0]};
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  // output word chosen at frame start; gpio read beats readback beats adc
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_reg <= '0;
    end else if (sync_fall) begin
      if (gpio_rd_reg) begin
        tx_reg <= {8'h00, pin_s & gpi_cfg_reg};
      end else if (drb_pend_reg) begin
        tx_reg <= {1'b1, drb_ch_reg, dac_reg[drb_ch_reg]};
      end else if (rb_pend_reg) begin
        tx_reg <= reg_value(rb_addr_reg);
      end else if (res_valid_reg) begin
        tx_reg <= res_frame_reg;
      end else begin
        tx_reg <= '0;
      end
    end else if (sclk_fall) begin
      tx_reg <= {tx_reg[FRAME_W-2:0], 1'b0};
    end
  end
  assign o_sdo = tx_reg[FRAME_W-1];

  function automatic logic [FRAME_W-1:0] reg_value(input logic [3:0] a);
    logic [FRAME_W-1:0] v;
    v = '0;
    unique case (a)
      A_ADC_SEQ:  v[NPIN-1:0] = seq_mask_reg;
      A_GP_CTRL:  v = {7'h00, busy_en_reg, 2'h0, o_adc_range, o_dac_gain, 4'h0};
      A_ADC_CFG:  v[NPIN-1:0] = adc_cfg_reg;
      A_DAC_CFG:  v[NPIN-1:0] = dac_cfg_reg;
      A_PULLDOWN: v[NPIN-1:0] = o_pulldown;
      A_GPO_CFG:  v[NPIN-1:0] = gpo_cfg_reg;
      A_GPO_DATA: v[NPIN-1:0] = gpo_data_reg;
      A_GPI_CFG:  v[NPIN-1:0] = gpi_cfg_reg;
      default:    v = '0;
    endcase
    return v;
  endfunction : reg_value

  ////////////////////////////////////////////////////////////////////////
  // control registers, written when a complete frame ends
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seq_mask_reg <= '0;
      adc_cfg_reg  <= '0;
      dac_cfg_reg  <= '0;
      gpo_cfg_reg  <= '0;
      gpo_data_reg <= '0;
      gpi_cfg_reg  <= '0;
      busy_en_reg  <= 1'b0;
      o_adc_range  <= 1'b0;
      o_dac_gain   <= 1'b0;
      o_pulldown   <= PULLDOWN_RST;
      o_ref_en     <= 1'b0;
      ld_mode_reg  <= LD_IMMED;
      rb_addr_reg  <= '0;
      drb_ch_reg   <= '0;
    end else if (exec && !rx_reg[B_IS_DAC]) begin
      unique case (addr)
        A_ADC_SEQ:  seq_mask_reg <= rx_reg[NPIN-1:0];
        A_GP_CTRL: begin
          busy_en_reg <= rx_reg[B_BUSY_EN];
          o_adc_range <= rx_reg[B_ADC_RANGE];
          o_dac_gain  <= rx_reg[B_DAC_GAIN];
        end
        A_ADC_CFG:  adc_cfg_reg  <= rx_reg[NPIN-1:0];
        A_DAC_CFG:  dac_cfg_reg  <= rx_reg[NPIN-1:0];
        A_PULLDOWN: o_pulldown   <= rx_reg[NPIN-1:0];
        A_RB_LOAD: begin
          ld_mode_reg <= rx_reg[1:0];
          rb_addr_reg <= rx_reg[RB_A_HI:RB_A_LO];
        end
        A_DAC_RB:   drb_ch_reg   <= rx_reg[CH_W-1:0];
        A_GPO_CFG:  gpo_cfg_reg  <= rx_reg[NPIN-1:0];
        A_GPO_DATA: gpo_data_reg <= rx_reg[NPIN-1:0];
        A_GPI_CFG:  gpi_cfg_reg  <= rx_reg[NPIN-1:0];
        A_PWR_DOWN: o_ref_en     <= rx_reg[B_REF_EN];
        default: ;
      endcase
    end
  end

  // one-shot read requests; set at frame end, used at the next frame start
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gpio_rd_reg  <= 1'b0;
      rb_pend_reg  <= 1'b0;
      drb_pend_reg <= 1'b0;
    end else if (exec && !rx_reg[B_IS_DAC]) begin
      gpio_rd_reg  <= gpio_rd_reg | (addr == A_GPI_CFG && rx_reg[B_GPIO_RD]);
      rb_pend_reg  <= rb_pend_reg | (addr == A_RB_LOAD && rx_reg[B_RB_EN]);
      drb_pend_reg <= drb_pend_reg
                      | (addr == A_DAC_RB && rx_reg[DRB_EN_HI:DRB_EN_LO] == DRB_ON);
    end else if (sync_fall) begin
      gpio_rd_reg  <= 1'b0;
      rb_pend_reg  <= gpio_rd_reg & rb_pend_reg;
      drb_pend_reg <= gpio_rd_reg & drb_pend_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dac input and output registers per channel
  for (genvar g = 0; g < NPIN; g++) begin : g_dac
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        in_reg[g]  <= '0;
        dac_reg[g] <= '0;
      end else if (exec && rx_reg[B_IS_DAC] && wch == g) begin
        in_reg[g] <= rx_reg[DATA_W-1:0];
        if (ld_mode_reg == LD_IMMED) begin
          dac_reg[g] <= rx_reg[DATA_W-1:0];
        end
      end else if (exec && !rx_reg[B_IS_DAC] && addr == A_RB_LOAD
                   && rx_reg[1:0] == LD_LOAD) begin
        // a dac word whose code bits mimic a load command must not load
        dac_reg[g] <= in_reg[g];
      end
    end
    assign o_dac_code[g*DATA_W +: DATA_W] = dac_reg[g];
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer; a conversion start is refused while one is running
  assign conv_start = sync_fall && seq_mask_reg != '0 && !busy_reg;
  assign conv_done  = busy_reg && tmr_reg == '0;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chan_reg    <= '0;
      conv_ch_reg <= '0;
    end else if (exec && !rx_reg[B_IS_DAC] && addr == A_ADC_SEQ) begin
      chan_reg <= next_chan(rx_reg[NPIN-1:0], 3'h7);
    end else if (conv_start) begin
      conv_ch_reg <= chan_reg;
      chan_reg    <= next_chan(seq_mask_reg, chan_reg);
    end
  end

  // conversion timer; counts the fixed conversion time
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_reg <= 1'b0;
      tmr_reg  <= '0;
    end else if (conv_start) begin
      busy_reg <= 1'b1;
      tmr_reg  <= TMR_W'(CONV_CYC - 1);
    end else if (conv_done) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      tmr_reg <= tmr_reg - 10'h001;
    end
  end

  // result frame held until shipped; a new result wins over the send
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      res_valid_reg <= 1'b0;
      res_frame_reg <= '0;
    end else if (conv_done) begin
      res_valid_reg <= 1'b1;
      res_frame_reg <= {1'b0, conv_ch_reg, i_adc_result};
    end else if (sync_fall && !gpio_rd_reg && !rb_pend_reg && !drb_pend_reg) begin
      res_valid_reg <= 1'b0;
    end
  end

  assign o_adc_busy  = busy_reg;
  assign o_adc_track = seq_mask_reg != '0 && !busy_reg;
  assign o_adc_chan  = busy_reg ? conv_ch_reg : chan_reg;
  assign o_adc_en    = adc_cfg_reg;
  assign o_dac_en    = dac_cfg_reg;

  ////////////////////////////////////////////////////////////////////////
  // pin drivers; dac owns a pin first, then the busy flag, then gpio
  always_comb begin
    o_pin    = gpo_data_reg;
    o_pin_oe = gpo_cfg_reg & ~dac_cfg_reg;
    // the flag gives way when the pin is a dac output
    if (busy_en_reg && !dac_cfg_reg[FLAG_PIN]) begin
      o_pin[FLAG_PIN]    = ~busy_reg;
      o_pin_oe[FLAG_PIN] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [TMR_W-1:0] age_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      age_reg <= '0;
    end else begin
      age_reg <= busy_reg ? age_reg + 10'h001 : '0;
    end
  end

  a_conv_time: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(busy_reg) |-> $past(age_reg) == TMR_W'(CONV_CYC - 1))
    else $error("conversion length wrong");
  a_seq_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    conv_start |=> busy_reg && conv_ch_reg == $past(chan_reg))
    else $error("conversion did not start on frame fall");
  a_seq_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    conv_start |=> chan_reg == next_chan(seq_mask_reg, conv_ch_reg))
    else $error("sequence did not advance");
  a_frame_form: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(res_valid_reg) |-> !res_frame_reg[FRAME_W-1]
      && res_frame_reg[CH_HI:CH_LO] == conv_ch_reg)
    else $error("result frame malformed");
  a_flag_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    busy_en_reg && !dac_cfg_reg[FLAG_PIN]
      |-> o_pin_oe[FLAG_PIN] && o_pin[FLAG_PIN] == !busy_reg)
    else $error("flag pin wrong");
  a_dac_immed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    exec && rx_reg[B_IS_DAC] && ld_mode_reg == LD_IMMED
      |=> dac_reg[$past(wch)] == $past(rx_reg[DATA_W-1:0]))
    else $error("dac not updated at once");
  a_dac_defer: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    exec && rx_reg[B_IS_DAC] && ld_mode_reg == LD_DEFER
      |=> dac_reg[$past(wch)] == $past(dac_reg[wch]))
    else $error("deferred dac updated");
  a_gpo_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ((o_pin ^ gpo_data_reg) & o_pin_oe & ~(NPIN'(busy_en_reg) << FLAG_PIN)) == '0)
    else $error("gpio output level wrong");
  a_ref_enable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_ref_en) |-> $past(exec && addr == A_PWR_DOWN && rx_reg[B_REF_EN]))
    else $error("reference enabled without write");
  a_gpio_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sync_fall && gpio_rd_reg |=> tx_reg == {8'h00, $past(pin_s & gpi_cfg_reg)})
    else $error("gpio readback wrong");
endmodule : cfgio_seq

/* File: hdl/cfgio_sync2.sv */
// two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module cfgio_sync2 #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= RST_VAL;
      o_q      <= RST_VAL;
    end else begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end
endmodule : cfgio_sync2

/* File: testbench/cfgio_host.sv */
// host-side serial master model driving the port sequencer link
`timescale 1ns/1ps
module cfgio_host (
  output logic      o_sclk,
  output logic      o_sync_n,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  ////////////////////////////////////////
  // idle: clock parked low, frame high
  initial begin
    o_sclk   = 1'b0;
    o_sync_n = 1'b1;
    o_sdi    = 1'b0;
  end

  ////////////////////////////////////////
  // one frame msb first at a 125 ns clock; n below 16 gives a short frame
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    #1.3 o_sync_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      #62.5 o_sclk = 1'b1;
      r = {r[14:0], i_sdo};                 // sample before the data moves
      o_sdi = w[i];
      #62.5 o_sclk = 1'b0;
    end
    #62.5 o_sync_n = 1'b1;
    o_sdi = ~o_sdi;                         // released line, no pull: show inverse
    #40;                                    // gap above 20 ns, lets the command land
  endtask : xfer
endmodule : cfgio_host

/* File: testbench/tb_config_io_port_sequencer.sv */
// self-checking bench for the configurable i/o port sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_config_io_port_sequencer
  import cfgio_pkg::*;
;
  logic                   i_clk, i_rst_n, sclk, sync_n, sdi, sdo;
  logic                   busy, track, gain, range, ref_en;
  logic [NPIN-1:0]        pin_w, ext, o_pin, oe, dac_en, adc_en, pd;
  logic [NPIN*DATA_W-1:0] dac_code;
  logic [CH_W-1:0]        chan, cur_ch;
  logic [DATA_W-1:0]      adc_res;
  logic [15:0]            r;
  logic [11:0]            dac_m [8];
  int                     bad_count, check_count, seed, run;

  ////////////////////////////////////////
  // 250 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // pin wire: device drive wins where enabled, else outside level
  assign pin_w = (oe & o_pin) | (~oe & ext);

  cfgio_seq dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_sync_n(sync_n), .i_sdi(sdi),
    .o_sdo(sdo), .i_pin(pin_w), .o_pin(o_pin), .o_pin_oe(oe), .o_dac_code(dac_code),
    .o_dac_en(dac_en), .o_dac_gain(gain), .o_adc_en(adc_en), .o_adc_range(range),
    .o_adc_chan(chan), .o_adc_track(track), .o_adc_busy(busy), .i_adc_result(adc_res),
    .o_pulldown(pd), .o_ref_en(ref_en)
  );

  cfgio_host host (.o_sclk(sclk), .o_sync_n(sync_n), .o_sdi(sdi), .i_sdo(sdo));

  ////////////////////////////////////////
  // conversion length, mux channel and flag pin watched every cycle
  always @(posedge i_clk) begin
    if (busy === 1'b1) begin
      run++;
      `CHK(chan, cur_ch)
      `CHK({oe[FLAG_PIN], o_pin[FLAG_PIN]}, 2'b10)
    end else if (run != 0) begin
      `CHK(run, CONV_CYC)
      `CHK(o_pin[FLAG_PIN], 1'b1)
      run = 0;
    end
  end

  ////////////////////////////////////////
  task automatic cw(input logic [3:0] a, input logic [10:0] d);
    host.xfer({1'b0, a, d}, 16, r);
  endtask : cw

  task automatic done(input string s);
    $display("end of test %s", s);
  endtask : done

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  // bounded wait for the converter, then the tracking time before a new frame
  task automatic idle;
    int k;
    k = 0;
    while (busy === 1'b1 && k < 1000) begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 1000) begin
      bad_count++;
      summarize();
    end
    #500;
  endtask : idle

  ////////////////////////////////////////
  // main sequence: reset, config, dac, readback, gpio, adc sequence
  initial begin
    logic [2:0]  ch;
    logic [11:0] code;
    logic [15:0] e16;
    logic [15:0] exp_q[$];
    logic [2:0]  chs [3];
    seed = 66585;
    i_rst_n = 1'b0;
    ext = 8'h00;
    adc_res = 12'h000;
    cur_ch = 3'h0;
    run = 0;
    chs = '{3'h0, 3'h2, 3'h6};
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    `CHK({pd, ref_en, oe, dac_en, sdo}, {8'hFF, 1'b0, 8'h00, 8'h00, 1'b0})
    done("reset");
    // short frame is dropped, a whole one executes
    host.xfer({1'b0, A_PWR_DOWN, 11'h200}, 15, r);
    `CHK(ref_en, 1'b0)
    cw(A_PWR_DOWN, 11'h200);
    `CHK(ref_en, 1'b1)
    done("reference");
    cw(A_DAC_CFG, 11'h00F);
    cw(A_ADC_CFG, 11'h045);
    cw(A_GP_CTRL, 11'h130);
    `CHK({dac_en, adc_en, gain, range}, {8'h0F, 8'h45, 2'b11})
    // extremes first, then random codes
    for (int i = 0; i < 8; i++) begin
      ch = 3'(i % 4);
      code = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($random(seed));
      host.xfer({1'b1, ch, code}, 16, r);
      dac_m[ch] = code;
      `CHK(dac_code[ch*DATA_W +: DATA_W], code)
    end
    cw(A_RB_LOAD, {9'h000, LD_DEFER});
    host.xfer({1'b1, 3'h1, 12'hA5C}, 16, r);
    `CHK(dac_code[DATA_W +: DATA_W], dac_m[1])
    cw(A_RB_LOAD, {9'h000, LD_LOAD});
    `CHK(dac_code[DATA_W +: DATA_W], 12'hA5C)
    // deferred words whose code bits look like a load command stay held
    cw(A_RB_LOAD, {9'h000, LD_DEFER});
    host.xfer({1'b1, 3'h2, 12'h123}, 16, r);
    host.xfer({1'b1, 3'h3, 12'h802}, 16, r);
    `CHK(dac_code[47:24], {dac_m[3], dac_m[2]})
    done("dac");
    // readback answers on the frame after the select
    cw(A_RB_LOAD, 11'h054);
    cw(A_RB_LOAD, 11'h000);
    `CHK(r, 16'h000F)
    cw(A_DAC_RB, 11'h019);
    cw(A_DAC_RB, 11'h000);
    `CHK(r, 16'h9A5C)
    done("readback");
    @(posedge i_clk);
    ext <= 8'($random(seed));
    cw(A_GPO_CFG, 11'h030);
    cw(A_GPO_DATA, 11'h020);
    `CHK({oe[5:4], o_pin[5:4]}, 4'b1110)
    cw(A_GPI_CFG, 11'h460);
    cw(A_GPI_CFG, 11'h060);
    `CHK(r, {9'h000, ext[6], 6'h20})
    cw(A_PULLDOWN, 11'h0A5);
    `CHK(pd, 8'hA5)
    done("gpio");
    cw(A_ADC_SEQ, 11'h045);
    `CHK({track, chan}, 4'b1000)
    #500;
    // five frames over three channels: the sequence wraps
    for (int k = 0; k < 5; k++) begin
      cur_ch = chs[k % 3];
      code = 12'($random(seed));
      @(posedge i_clk);
      adc_res <= code;
      host.xfer(16'h0000, 16, r);
      e16 = (k == 0) ? 16'h0000 : exp_q.pop_front();
      `CHK(r, e16)
      exp_q.push_back({1'b0, cur_ch, code});
      idle();
    end
    done("adc");
    summarize();
  end
endmodule : tb_config_io_port_sequencer
